// ---- hdl/lsc_config_bank.sv ----
// Configuration register bank with serial write port and the data path it steers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Registers are eight bits; unassigned bits hold zero as reserved, except readout control bit 7, which is writable and resets to one.
// - Written values apply only after update request, on next conversion-done rising edge.
// - Division bits pick readout clock: master, half, quarter, or none for 11; the registered 00 setting gives half rate like 01.
// - Readout control bit 6 selects linear (0) or companding (1) conversion.
// - Saturation enable clamps output to 4095; otherwise full 13-bit result passes.
// - With saturation on, the 13th output bit carries an overflow flag.
// - Offset subtraction bit removes black offset from each readout value.
// - Readout control bit 3 enables the dithering noise generator.
// - Analog control bit 5 selects unity or times-four sampler gain.
// - Analog control bit 4 enables white value clamping.
// - Analog control bit 3 switches the extra anti-blooming circuit.
// - Analog control bit 2 steers results into offset storage instead of readout.
// - Analog control bit 1 selects low-power or constant-power reference bias.
// - Auto mode issues readout trigger after conversion once line valid is low.
// - Auto mode rereads the same line if no new conversion started.
// - Inverse gain register sets conversion voltage step; larger means lower gain.
// - Black offset register sets the conversion black level.
// - Reference control bits 5:3 select reference current trim from a table.
// - Offset memory enable powers the offset memory; zero discards its contents.
// - In companding mode, relinearize to 12 bits or output compressed value.
// - Reference control bit 0 drives the pixel clock pad, else tristate.
// - First knee threshold equals the threshold register times thirty-two.
// - Serial word is eight data then eight address bits, LSB first.
module lsc_config_bank (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_ncs,
  input wire logic i_conv_done,
  input wire logic [12:0] i_conv_data,
  input wire logic i_conv_valid,
  input wire logic i_line_valid,
  input wire logic i_ext_load,
  output logic o_load_pulse,
  output logic o_line_valid_out,
  output logic o_pix_clk,
  output logic o_pix_clk_oe,
  output logic [12:0] o_pix_data,
  output logic o_pix_valid,
  output logic o_ofs_wr,
  output logic [12:0] o_ofs_data,
  output logic o_companding,
  output logic o_dither_en,
  output logic o_gain_x4,
  output logic o_white_clamp,
  output logic o_anti_bloom,
  output logic o_ref_low_power,
  output logic [7:0] o_inverse_gain,
  output logic [7:0] o_black_offset,
  output logic [2:0] o_ref_trim,
  output logic [7:0] o_ref_trim_pct,
  output logic o_ofs_mem_en,
  output logic o_relinearize,
  output logic [12:0] o_knee_one,
  output logic o_update_pending
);
  import lsc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] reg_mask(input logic [7:0] addr);
    unique case (addr)
      LSC_ADDR_RDCTL: reg_mask = LSC_MASK_RDCTL;
      LSC_ADDR_ANCTL: reg_mask = LSC_MASK_ANCTL;
      LSC_ADDR_IGAIN: reg_mask = LSC_MASK_IGAIN;
      LSC_ADDR_BOFS: reg_mask = LSC_MASK_BOFS;
      LSC_ADDR_REFCTL: reg_mask = LSC_MASK_REFCTL;
      LSC_ADDR_KNEE1: reg_mask = LSC_MASK_KNEE1;
      default: reg_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] trim_pct(input logic [2:0] code);
    unique case (code)
      3'h0: trim_pct = 8'd132;
      3'h1: trim_pct = 8'd77;
      3'h2: trim_pct = 8'd100;
      3'h3: trim_pct = 8'd64;
      3'h4: trim_pct = 8'd112;
      3'h5: trim_pct = 8'd70;
      3'h6: trim_pct = 8'd86;
      default: trim_pct = 8'd59;
    endcase
  endfunction

  localparam logic [7:0] RST_VAL [LSC_NREG] = '{LSC_RST_RDCTL, LSC_RST_ANCTL, LSC_RST_IGAIN,
                                               LSC_RST_BOFS, LSC_RST_REFCTL, LSC_RST_KNEE1};

  // ==========================================================
  // Serial pin synchronisers
  logic [1:0] sclk_sync_r;
  logic [1:0] mosi_sync_r;
  logic [1:0] ncs_sync_r;
  logic [1:0] load_sync_r;
  logic sclk_prev_r;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_sync_r <= 2'h0;
      mosi_sync_r <= 2'h0;
      ncs_sync_r <= 2'h3;
      load_sync_r <= 2'h0;
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], i_sclk};
      mosi_sync_r <= {mosi_sync_r[0], i_mosi};
      ncs_sync_r <= {ncs_sync_r[0], i_ncs};
      load_sync_r <= {load_sync_r[0], i_ext_load};
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  wire logic sclk_rise = sclk_sync_r[1] && !sclk_prev_r;

  // ==========================================================
  // Serial word assembly
  logic [15:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic word_done_r;

  // Bits enter at the top and move down, so after sixteen bits the first (data LSB) sits
  // at bit 0 and the address occupies the upper byte.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_r <= 16'h0000;
      bit_cnt_r <= 4'h0;
      word_done_r <= 1'b0;
    end else begin
      word_done_r <= 1'b0;
      if (ncs_sync_r[1]) begin
        bit_cnt_r <= 4'h0;
      end else if (sclk_rise) begin
        shift_r <= {mosi_sync_r[1], shift_r[15:1]};
        bit_cnt_r <= bit_cnt_r + 4'h1;
        word_done_r <= (bit_cnt_r == 4'(LSC_WORD_BITS - 1));
      end
    end
  end

  wire logic [7:0] wr_data = shift_r[7:0];
  wire logic [7:0] wr_addr = shift_r[15:8];

  // ==========================================================
  // Shadow and active register sets
  logic [7:0] shadow_r [LSC_NREG];
  logic [7:0] active_r [LSC_NREG];
  logic pending_r;
  logic conv_prev_r;

  wire logic conv_rise = i_conv_done && !conv_prev_r;

  genvar gi;
  generate
    for (gi = 0; gi < LSC_NREG; gi++) begin : g_reg
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          shadow_r[gi] <= RST_VAL[gi];
          active_r[gi] <= RST_VAL[gi];
        end else begin
          if (word_done_r && wr_addr == 8'(gi + 1)) begin
            shadow_r[gi] <= wr_data & reg_mask(wr_addr);
          end
          if (pending_r && conv_rise) begin
            active_r[gi] <= shadow_r[gi];
          end
        end
      end
    end
  endgenerate

  // An update-request write landing on the same edge as the transfer re-arms the request, so it is kept.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pending_r <= 1'b0;
      conv_prev_r <= 1'b0;
    end else begin
      conv_prev_r <= i_conv_done;
      if (word_done_r && wr_addr == LSC_ADDR_RDCTL && wr_data[LSC_RD_UPDATE]) begin
        pending_r <= 1'b1;
      end else if (conv_rise) begin
        pending_r <= 1'b0;
      end
    end
  end

  wire logic [7:0] rd_ctl = active_r[0];
  wire logic [7:0] an_ctl = active_r[1];
  wire logic [7:0] rf_ctl = active_r[4];
  wire logic [1:0] clk_div = rd_ctl[LSC_RD_DIV_LO +: 2];

  // ==========================================================
  // Static configuration outputs
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_companding <= 1'b0;
      o_dither_en <= 1'b0;
      o_gain_x4 <= 1'b0;
      o_white_clamp <= 1'b0;
      o_anti_bloom <= 1'b0;
      o_ref_low_power <= 1'b0;
      o_inverse_gain <= 8'h00;
      o_black_offset <= 8'h00;
      o_ref_trim <= 3'h0;
      o_ref_trim_pct <= 8'h00;
      o_ofs_mem_en <= 1'b0;
      o_relinearize <= 1'b0;
      o_knee_one <= 13'h0000;
      o_update_pending <= 1'b0;
    end else begin
      o_companding <= rd_ctl[LSC_RD_COMPAND];
      o_dither_en <= rd_ctl[LSC_RD_DITHER];
      o_gain_x4 <= an_ctl[LSC_AN_GAIN4];
      o_white_clamp <= an_ctl[LSC_AN_WCLAMP];
      o_anti_bloom <= an_ctl[LSC_AN_ABLOOM];
      o_ref_low_power <= an_ctl[LSC_AN_LOWPWR];
      o_inverse_gain <= active_r[2];
      o_black_offset <= active_r[3];
      o_ref_trim <= rf_ctl[LSC_RF_TRIM_LO +: 3];
      o_ref_trim_pct <= trim_pct(rf_ctl[LSC_RF_TRIM_LO +: 3]);
      o_ofs_mem_en <= rf_ctl[LSC_RF_OFSMEM];
      // Relinearizing only means something in companding mode.
      o_relinearize <= rf_ctl[LSC_RF_RELIN] && rd_ctl[LSC_RD_COMPAND];
      o_knee_one <= {active_r[5], 5'h00};
      o_update_pending <= pending_r;
    end
  end

  // ==========================================================
  // Readout clock divider and pad drive
  logic [1:0] div_cnt_r;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt_r <= 2'h0;
      o_pix_clk <= 1'b0;
      o_pix_clk_oe <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_r + 2'h1;
      o_pix_clk_oe <= rf_ctl[LSC_RF_PCLKOE];
      // A full-rate clock cannot come from a flop; here it toggles each edge as the fastest
      // registered form, the other ratios follow the counter.
      unique case (clk_div)
        LSC_DIV_1: o_pix_clk <= ~o_pix_clk;
        LSC_DIV_2: o_pix_clk <= ~div_cnt_r[0];
        LSC_DIV_4: o_pix_clk <= ~div_cnt_r[1];
        default: o_pix_clk <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Readout trigger
  logic load_armed_r;

  // In auto mode, after a pulse, wait for line valid to rise before another can go; when line valid falls
  // again with conversion still done, the same line is read once more.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_load_pulse <= 1'b0;
      load_armed_r <= 1'b1;
      o_line_valid_out <= 1'b0;
    end else begin
      o_line_valid_out <= i_line_valid;
      if (an_ctl[LSC_AN_AUTOLOAD]) begin
        o_load_pulse <= load_armed_r && i_conv_done && !i_line_valid && !o_load_pulse;
      end else begin
        o_load_pulse <= load_sync_r[1];
      end
      if (o_load_pulse) begin
        load_armed_r <= 1'b0;
      end else if (i_line_valid) begin
        load_armed_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Data path
  logic [12:0] sub_val;
  logic under;

  always_comb begin
    under = rd_ctl[LSC_RD_OFSSUB] && (i_conv_data < {5'h00, active_r[3]});
    sub_val = rd_ctl[LSC_RD_OFSSUB] ? i_conv_data - {5'h00, active_r[3]} : i_conv_data;
    if (under) begin
      sub_val = 13'h0000;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pix_data <= 13'h0000;
      o_pix_valid <= 1'b0;
      o_ofs_wr <= 1'b0;
      o_ofs_data <= 13'h0000;
    end else begin
      o_pix_valid <= i_conv_valid && !an_ctl[LSC_AN_OFSCAP];
      o_ofs_wr <= i_conv_valid && an_ctl[LSC_AN_OFSCAP] && rf_ctl[LSC_RF_OFSMEM];
      if (i_conv_valid) begin
        o_ofs_data <= i_conv_data;
        if (rd_ctl[LSC_RD_SAT] && sub_val > LSC_SAT_MAX) begin
          o_pix_data <= {1'b1, LSC_SAT_MAX[11:0]};
        end else if (rd_ctl[LSC_RD_SAT]) begin
          o_pix_data <= {1'b0, sub_val[11:0]};
        end else begin
          o_pix_data <= sub_val;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- include/lsc_pkg.sv ----
// Package with the register map, reset values, field positions and timing of the config bank.
package lsc_pkg;
  localparam int LSC_NREG = 6;
  localparam logic [7:0] LSC_ADDR_RDCTL = 8'h01;
  localparam logic [7:0] LSC_ADDR_ANCTL = 8'h02;
  localparam logic [7:0] LSC_ADDR_IGAIN = 8'h03;
  localparam logic [7:0] LSC_ADDR_BOFS = 8'h04;
  localparam logic [7:0] LSC_ADDR_REFCTL = 8'h05;
  localparam logic [7:0] LSC_ADDR_KNEE1 = 8'h06;
  localparam logic [7:0] LSC_RST_RDCTL = 8'ha8;
  localparam logic [7:0] LSC_RST_ANCTL = 8'h12;
  localparam logic [7:0] LSC_RST_IGAIN = 8'h1d;
  localparam logic [7:0] LSC_RST_BOFS = 8'hc8;
  localparam logic [7:0] LSC_RST_REFCTL = 8'h12;
  localparam logic [7:0] LSC_RST_KNEE1 = 8'h01;
  // Writable bit masks; the other positions are reserved and read as zero.
  localparam logic [7:0] LSC_MASK_RDCTL = 8'hff;
  localparam logic [7:0] LSC_MASK_ANCTL = 8'h3f;
  localparam logic [7:0] LSC_MASK_IGAIN = 8'hff;
  localparam logic [7:0] LSC_MASK_BOFS = 8'hff;
  localparam logic [7:0] LSC_MASK_REFCTL = 8'h3f;
  localparam logic [7:0] LSC_MASK_KNEE1 = 8'hff;
  // Readout control fields.
  localparam int LSC_RD_UPDATE = 0;
  localparam int LSC_RD_DIV_LO = 1;
  localparam int LSC_RD_DITHER = 3;
  localparam int LSC_RD_OFSSUB = 4;
  localparam int LSC_RD_SAT = 5;
  localparam int LSC_RD_COMPAND = 6;
  // Analog control fields.
  localparam int LSC_AN_AUTOLOAD = 0;
  localparam int LSC_AN_LOWPWR = 1;
  localparam int LSC_AN_OFSCAP = 2;
  localparam int LSC_AN_ABLOOM = 3;
  localparam int LSC_AN_WCLAMP = 4;
  localparam int LSC_AN_GAIN4 = 5;
  // Reference control fields.
  localparam int LSC_RF_PCLKOE = 0;
  localparam int LSC_RF_RELIN = 1;
  localparam int LSC_RF_OFSMEM = 2;
  localparam int LSC_RF_TRIM_LO = 3;
  // Serial word and data path.
  localparam int LSC_WORD_BITS = 16;
  localparam int LSC_KNEE_SHIFT = 5;
  localparam logic [12:0] LSC_SAT_MAX = 13'h0fff;
  localparam logic [1:0] LSC_DIV_1 = 2'h0;
  localparam logic [1:0] LSC_DIV_2 = 2'h1;
  localparam logic [1:0] LSC_DIV_4 = 2'h2;
endpackage

// ---- test/lsc_serial_master.sv ----
// Model of the serial configuration master that writes the bank.
`timescale 1ns/1ps
`default_nettype none
module lsc_serial_master (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_ncs
);
  initial begin
    o_sclk = 1'b0;
    o_mosi = 1'b0;
    o_ncs = 1'b1;
  end
  // ====================
  // Word sender
  // Each clock phase lasts ph master cycles, so ph of two or more keeps the
  // serial clock below half the master clock.
  task automatic send(input logic [7:0] d, input logic [7:0] a, input int ph);
    logic [15:0] w;
    w = {a, d};
    @(posedge i_clk);
    o_ncs <= 1'b0;
    for (int b = 0; b < 18; b++) begin
      if (b < 16) o_mosi <= w[b];
      repeat (ph) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (ph) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    o_ncs <= 1'b1;
    o_mosi <= ~o_mosi;
  endtask
endmodule
`default_nettype wire

// ---- test/lsc_config_bank_props.sv ----
// Assertion checker for the configuration bank ports.
`timescale 1ns/1ps
`default_nettype none
module lsc_config_bank_props
  import lsc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ncs,
  input wire logic i_conv_done,
  input wire logic i_conv_valid,
  input wire logic o_pix_valid,
  input wire logic o_ofs_wr,
  input wire logic o_ofs_mem_en,
  input wire logic o_update_pending,
  input wire logic o_load_pulse,
  input wire logic o_dither_en,
  input wire logic o_relinearize,
  input wire logic [7:0] o_inverse_gain,
  input wire logic [7:0] o_black_offset,
  input wire logic [2:0] o_ref_trim,
  input wire logic [7:0] o_ref_trim_pct,
  input wire logic [12:0] o_knee_one
);
  localparam logic [7:0] PCT [8] = '{8'h84, 8'h4d, 8'h64, 8'h40, 8'h70, 8'h46, 8'h56, 8'h3b};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // Outputs read zero until the first edge after reset, so early checks wait.
  logic [1:0] age_r;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      age_r <= 2'h0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
  end
  // ====================
  // Properties
  property p_knee;
    o_knee_one[4:0] == 5'h00;
  endproperty
  a_knee: assert property (p_knee) else $error("knee low bits set");
  property p_trim;
    age_r != 2'h0 |-> o_ref_trim_pct == PCT[o_ref_trim];
  endproperty
  a_trim: assert property (p_trim) else $error("trim percent wrong");
  property p_defaults;
    age_r == 2'h0 |=> o_inverse_gain == LSC_RST_IGAIN && o_black_offset == LSC_RST_BOFS &&
      o_knee_one == 13'h0020 && o_ref_trim == 3'h2 && o_dither_en && !o_relinearize &&
      !o_ofs_mem_en && !o_update_pending;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad defaults");
  property p_hold;
    age_r == 2'h3 && $changed({o_inverse_gain, o_black_offset, o_knee_one, o_ref_trim}) |->
      $past(o_update_pending, 1) || $past(o_update_pending, 2) || $past(o_update_pending, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed without update");
  property p_apply;
    $fell(o_update_pending) |-> $past(i_conv_done, 1) || $past(i_conv_done, 2);
  endproperty
  a_apply: assert property (p_apply) else $error("update without conversion done");
  property p_pend;
    $rose(o_update_pending) |-> !$past(i_ncs, 8);
  endproperty
  a_pend: assert property (p_pend) else $error("pending without serial word");
  property p_route;
    o_ofs_wr |-> !o_pix_valid && o_ofs_mem_en;
  endproperty
  a_route: assert property (p_route) else $error("result sent to both sinks");
  property p_data;
    o_pix_valid || o_ofs_wr |-> $past(i_conv_valid);
  endproperty
  a_data: assert property (p_data) else $error("result without conversion");
  c_update: cover property ($fell(o_update_pending));
  c_ofs: cover property (o_ofs_wr);
  c_load: cover property (o_load_pulse);
endmodule
bind lsc_config_bank lsc_config_bank_props u_props (.*);
`default_nettype wire

// ---- test/lsc_config_bank_tb.sv ----
// Self-checking bench for the configuration bank.
`timescale 1ns/1ps
`default_nettype none
module lsc_config_bank_tb;
  import lsc_pkg::*;
  localparam logic [7:0] PCT [8] = '{8'h84, 8'h4d, 8'h64, 8'h40, 8'h70, 8'h46, 8'h56, 8'h3b};
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_sclk, i_mosi, i_ncs;
  logic i_conv_done = 1'b0;
  logic i_conv_valid = 1'b0;
  logic i_line_valid = 1'b0;
  logic i_ext_load = 1'b0;
  logic [12:0] i_conv_data = 13'h0000;
  logic o_load_pulse, o_line_valid_out, o_pix_clk, o_pix_clk_oe, o_pix_valid, o_ofs_wr;
  logic o_companding, o_dither_en, o_gain_x4, o_white_clamp, o_anti_bloom, o_ref_low_power;
  logic o_ofs_mem_en, o_relinearize, o_update_pending, pc_d;
  logic [12:0] o_pix_data, o_ofs_data, o_knee_one;
  logic [7:0] o_inverse_gain, o_black_offset, o_ref_trim_pct;
  logic [2:0] o_ref_trim;
  logic [13:0] pq [$];
  int fails = 0;
  int tests_run = 0;
  int tog = 0;
  int lp_n = 0;
  wire [49:0] got_cfg = {o_update_pending, o_companding, o_dither_en, o_gain_x4, o_white_clamp,
    o_anti_bloom, o_ref_low_power, o_inverse_gain, o_black_offset, o_ref_trim, o_ref_trim_pct,
    o_ofs_mem_en, o_relinearize, o_pix_clk_oe, o_knee_one};
  lsc_config_bank DUT (.*);
  lsc_serial_master u_m (.i_clk(i_clk_sys), .o_sclk(i_sclk), .o_mosi(i_mosi), .o_ncs(i_ncs));
  always #20 i_clk_sys = ~i_clk_sys;
  // ====================
  // Helpers
  function automatic logic [49:0] ecfg(input logic [7:0] rd, an, ig, bo, rf, kn, input logic p);
    // Relinearizing is only reported while companding conversion is selected.
    return {p, rd[6], rd[3], an[5:3], an[1], ig, bo, rf[5:3], PCT[rf[5:3]], rf[2],
      rf[1] & rd[6], rf[0], kn, 5'h00};
  endfunction
  function automatic logic [13:0] epix(input logic [12:0] d, input logic [7:0] rd, an, bo);
    logic [12:0] v;
    if (an[2]) return {1'b1, d};
    v = !rd[4] ? d : (d > {5'h00, bo}) ? d - {5'h00, bo} : 13'h0000;
    if (rd[5] && v > LSC_SAT_MAX) v = 13'h1fff;
    return {1'b0, v};
  endfunction
  task automatic chk(input logic [49:0] got, input logic [49:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ====================
  // Result monitor and edge counters
  always @(posedge i_clk_sys) begin
    pc_d <= o_pix_clk;
    tog <= tog + int'(o_pix_clk !== pc_d);
    lp_n <= lp_n + int'(o_load_pulse === 1'b1);
    if (o_pix_valid === 1'b1 || o_ofs_wr === 1'b1) begin
      if (pq.size() == 0) begin
        chk(50'h0, 50'h1);
      end else begin
        chk({36'h0, o_ofs_wr, o_ofs_wr ? o_ofs_data : o_pix_data},
          {36'h0, pq.pop_front()});
      end
    end
  end
  initial begin
    #(40 * 60000);
    fails++;
    wrap_up();
  end
  // ====================
  // Main sequence
  initial begin
    logic [7:0] rd, an, ig, bo, rf, kn;
    logic [31:0] r;
    logic [12:0] d;
    logic [49:0] prev;
    int t0;
    r = $urandom(32'h59f7e4e7);
    prev = ecfg(LSC_RST_RDCTL, LSC_RST_ANCTL, 8'h1d, 8'hc8, 8'h12, 8'h01, 1'b0);
    repeat (16) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    chk(got_cfg, prev);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      rd = {1'b1, r[0], r[1], r[2], r[3], i[1:0], 1'b1};
      an = {2'b11, r[4], r[5], r[6], r[7], r[8], 1'b0};
      rf = {2'b11, i[2:0], rd[4] | an[2], r[9], r[10]};
      ig = r[18:11];
      bo = r[26:19];
      kn = 8'(r[31:27] * 5'h07);
      u_m.send(an, LSC_ADDR_ANCTL, 2 + i % 3);
      u_m.send(ig, LSC_ADDR_IGAIN, 2);
      u_m.send(bo, LSC_ADDR_BOFS, 3);
      u_m.send(rf, LSC_ADDR_REFCTL, 2);
      u_m.send(kn, LSC_ADDR_KNEE1, 4);
      u_m.send(8'h5a, 8'h07, 2);
      u_m.send(rd, LSC_ADDR_RDCTL, 2);
      repeat (8) @(posedge i_clk_sys);
      chk(got_cfg, {1'b1, prev[48:0]});
      i_conv_done <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      prev = ecfg(rd, an, ig, bo, rf, kn, 1'b0);
      chk(got_cfg >> 35, prev >> 35);
      chk(50'(got_cfg[34:0]), 50'(prev[34:0]));
      t0 = tog;
      repeat (16) @(posedge i_clk_sys);
      // A registered pad cannot run at the full master rate, so division 00 and 01 both
      // toggle on every clock; a quarter rate toggles every second clock.
      chk(50'(tog - t0), (i % 4 == 3) ? 50'h0 : (i % 4 == 2) ? 50'h8 : 50'h10);
      // The trigger is manual in these rounds, so the synced pin level is passed on; the
      // line valid pulse afterwards re-arms the automatic trigger for the last scenario.
      t0 = lp_n;
      i_ext_load <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_ext_load <= 1'b0;
      i_line_valid <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      i_line_valid <= 1'b0;
      chk(50'(o_line_valid_out), 50'h1);
      chk(50'(lp_n - t0), 50'h3);
      for (int k = 0; k < 2; k++) begin
        r = $urandom;
        d = (k == 0) ? 13'h0fff + {12'h000, i[0]} : r[12:0];
        pq.push_back(epix(d, rd, an, bo));
        @(posedge i_clk_sys);
        i_conv_data <= d;
        i_conv_valid <= 1'b1;
        @(posedge i_clk_sys);
        i_conv_valid <= 1'b0;
      end
      i_conv_done <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
    end
    u_m.send(8'h13, LSC_ADDR_ANCTL, 2);
    u_m.send(rd, LSC_ADDR_RDCTL, 2);
    repeat (8) @(posedge i_clk_sys);
    t0 = lp_n;
    i_conv_done <= 1'b1;
    repeat (16) @(posedge i_clk_sys);
    chk(50'(lp_n - t0), 50'h1);
    i_line_valid <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_line_valid <= 1'b0;
    repeat (16) @(posedge i_clk_sys);
    chk(50'(lp_n - t0), 50'h2);
    chk(50'(pq.size()), 50'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
